// >>> hw/lpp_port.v
/*
  Link-side port toward a serial-bus PHY: link request, control and data
  lines, received byte assembly, half-rate aux clock and bus cycle tick.
  Assumes all inputs are synchronous to i_ref_clk and the PHY keeps the
  published link/PHY handshake.
*/
`timescale 1ns/1ps
`include "lpp_regs.vh"

module lpp_port #(
  parameter FIFO_DEPTH = `LPP_FIFO_DEPTH,
  parameter FIFO_AW    = 5
) (
  input  wire       i_ref_clk,
  input  wire       i_rst,
  input  wire [1:0] i_speed,
  input  wire [7:0] i_tx_data,
  input  wire       i_tx_last,
  input  wire       i_tx_valid,
  output wire       o_tx_ready,
  input  wire       i_reg_req,
  input  wire       i_reg_write,
  input  wire [3:0] i_reg_addr,
  input  wire [7:0] i_reg_wdata,
  output wire       o_reg_ready,
  output reg  [7:0] o_rx_data,
  output reg        o_rx_valid,
  output reg        o_rx_end,
  output reg  [7:0] o_status_data,
  output reg        o_status_valid,
  input  wire [0:1] i_link_phy_control_lines,
  output reg  [0:1] o_link_phy_control_lines,
  output reg        o_link_phy_control_lines_oe,
  input  wire [0:7] i_phy_data,
  output reg  [0:7] o_phy_data,
  output reg        o_phy_data_oe,
  output reg        o_link_request,
  input  wire       i_iso_select_n,
  output reg        o_bushold_enable,
  output reg        o_half_rate_aux_clock,
  input  wire       i_external_cycle_start,
  input  wire       i_cycle_source_ext,
  output reg        o_cycle_tick_output
);

  // ----------------------------------------------------------------------
  // Constants and state
  // ----------------------------------------------------------------------
  localparam [2:0] S_IDLE = 3'h0;
  localparam [2:0] S_REQ  = 3'h1;
  localparam [2:0] S_WAIT = 3'h2;
  localparam [2:0] S_TX   = 3'h3;
  localparam [2:0] S_END  = 3'h4;

  localparam integer CYCLE_CLKS = `LPP_BUS_CYCLE_NS / `LPP_CLK_PERIOD_NS;
  localparam integer CYCLE_END  = CYCLE_CLKS - 1;
  localparam [11:0]  CYCLE_LAST = CYCLE_END[11:0];

  reg  [2:0]  state_reg;
  reg  [16:0] link_request_sh_reg;
  reg  [4:0]  link_request_cnt_reg;
  reg         link_request_bus_reg;
  reg  [7:0]  tx_sh_reg;
  reg  [1:0]  tx_beat_reg;
  reg         tx_last_reg;
  reg  [7:0]  rx_acc_reg;
  reg  [1:0]  rx_beat_reg;
  reg         rx_act_reg;
  reg  [11:0] cyc_cnt_reg;
  reg         ext_prev_reg;

  wire [8:0] fifo_data;
  wire       fifo_valid;
  wire       fifo_pop;
  wire [1:0] beats_m1;
  wire       ctl_grant;
  wire       ctl_receive;
  wire       ctl_status;
  wire       ext_edge;

  // A beat count of four, two or one per byte follows the active lanes.
  assign beats_m1 = (i_speed == `LPP_SPD_100) ? 2'h3 :
                    (i_speed == `LPP_SPD_200) ? 2'h1 : 2'h0;

  // Control inputs are only meaningful while the PHY owns the lines.
  assign ctl_grant   = !o_link_phy_control_lines_oe && (i_link_phy_control_lines == `LPP_CTL_GRANT);
  assign ctl_receive = !o_link_phy_control_lines_oe && (i_link_phy_control_lines == `LPP_CTL_RECEIVE);
  assign ctl_status  = !o_link_phy_control_lines_oe && (i_link_phy_control_lines == `LPP_CTL_STATUS);

  assign o_reg_ready = (state_reg == S_IDLE);
  assign fifo_pop    = (state_reg == S_TX) && (tx_beat_reg == 2'h0) && fifo_valid;
  assign ext_edge    = i_external_cycle_start && !ext_prev_reg;

  // ----------------------------------------------------------------------
  // Transmit buffer
  // ----------------------------------------------------------------------
  lpp_fifo #(
    .DW    (9),
    .DEPTH (FIFO_DEPTH),
    .AW    (FIFO_AW)
  ) u_fifo (
    .i_ref_clk  (i_ref_clk),
    .i_rst      (i_rst),
    .i_wr_data  ({i_tx_last, i_tx_data}),
    .i_wr_valid (i_tx_valid),
    .o_wr_ready (o_tx_ready),
    .o_rd_data  (fifo_data),
    .o_rd_valid (fifo_valid),
    .i_rd_ready (fifo_pop)
  );

  // Lane zero is the MSB, so a byte's top bits land on the low lane indices.
  function [0:7] lane_place;
    input [7:0] byte_in;
    input [1:0] spd;
    begin
      case (spd)
        `LPP_SPD_100: lane_place = {byte_in[7:6], 6'h00};
        `LPP_SPD_200: lane_place = {byte_in[7:4], 4'h0};
        default:      lane_place = byte_in;
      endcase
    end
  endfunction

  // ----------------------------------------------------------------------
  // Request, grant and transmit sequence
  // ----------------------------------------------------------------------
  always @(posedge i_ref_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      state_reg                   <= S_IDLE;
      link_request_sh_reg                 <= 17'h00000;
      link_request_cnt_reg                <= 5'h00;
      link_request_bus_reg                <= 1'b0;
      o_link_request              <= 1'b0;
      tx_sh_reg                   <= 8'h00;
      tx_beat_reg                 <= 2'h0;
      tx_last_reg                 <= 1'b0;
      o_phy_data                  <= 8'h00;
      o_phy_data_oe               <= 1'b0;
      o_link_phy_control_lines    <= `LPP_CTL_IDLE;
      o_link_phy_control_lines_oe <= 1'b0;
    end
    else
    begin
      case (state_reg)
        S_IDLE:
        begin
          // Register access is served ahead of a pending packet.
          if (i_reg_req)
          begin
            link_request_sh_reg  <= {1'b1, (i_reg_write ? `LPP_LINK_REQUEST_WRITE : `LPP_LINK_REQUEST_READ),
                             i_reg_addr, i_reg_wdata, 1'b0};
            link_request_cnt_reg <= `LPP_LINK_REQUEST_LEN;
            link_request_bus_reg <= 1'b0;
            state_reg    <= S_REQ;
          end
          else if (fifo_valid)
          begin
            link_request_sh_reg  <= {1'b1, `LPP_LINK_REQUEST_BUS, 13'h0000};
            link_request_bus_reg <= 1'b1;
            link_request_cnt_reg <= `LPP_LINK_REQUEST_LEN;
            state_reg    <= S_REQ;
          end
        end
        S_REQ:
        begin
          o_link_request <= link_request_sh_reg[16];
          link_request_sh_reg    <= {link_request_sh_reg[15:0], 1'b0};
          link_request_cnt_reg   <= link_request_cnt_reg - 5'h01;
          // The type field has shifted out by the last bit, so the request kind is kept aside.
          if (link_request_cnt_reg == 5'h01)
            state_reg <= link_request_bus_reg ? S_WAIT : S_IDLE;
        end
        S_WAIT:
        begin
          o_link_request <= 1'b0;
          if (ctl_grant)
          begin
            o_link_phy_control_lines    <= `LPP_CTL_TRANSMIT;
            o_link_phy_control_lines_oe <= 1'b1;
            o_phy_data                  <= 8'h00;
            o_phy_data_oe               <= 1'b1;
            tx_beat_reg                 <= 2'h0;
            state_reg                   <= S_TX;
          end
        end
        S_TX:
        begin
          if (tx_beat_reg != 2'h0)
          begin
            o_phy_data  <= lane_place(tx_sh_reg, i_speed);
            tx_sh_reg   <= (i_speed == `LPP_SPD_100) ? {tx_sh_reg[5:0], 2'h0} : {tx_sh_reg[3:0], 4'h0};
            tx_beat_reg <= tx_beat_reg - 2'h1;
            if (tx_beat_reg == 2'h1 && tx_last_reg)
              state_reg <= S_END;
          end
          else if (fifo_valid)
          begin
            o_phy_data  <= lane_place(fifo_data[7:0], i_speed);
            tx_sh_reg   <= (i_speed == `LPP_SPD_100) ? {fifo_data[5:0], 2'h0} : {fifo_data[3:0], 4'h0};
            tx_beat_reg <= beats_m1;
            tx_last_reg <= fifo_data[8];
            if (beats_m1 == 2'h0 && fifo_data[8])
              state_reg <= S_END;
          end
          else
          begin
            // Underrun: hold transmit with zero data until the buffer refills.
            o_phy_data <= 8'h00;
          end
        end
        S_END:
        begin
          // One idle cycle ends the packet before the lines are handed back.
          if (o_link_phy_control_lines == `LPP_CTL_TRANSMIT)
          begin
            o_link_phy_control_lines <= `LPP_CTL_IDLE;
            o_phy_data               <= 8'h00;
          end
          else
          begin
            o_link_phy_control_lines_oe <= 1'b0;
            o_phy_data_oe               <= 1'b0;
            tx_last_reg                 <= 1'b0;
            state_reg                   <= S_IDLE;
          end
        end
        default:
          state_reg <= S_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Receive and status capture
  // ----------------------------------------------------------------------
  always @(posedge i_ref_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      rx_acc_reg     <= 8'h00;
      rx_beat_reg    <= 2'h0;
      rx_act_reg     <= 1'b0;
      o_rx_data      <= 8'h00;
      o_rx_valid     <= 1'b0;
      o_rx_end       <= 1'b0;
      o_status_data  <= 8'h00;
      o_status_valid <= 1'b0;
    end
    else
    begin
      o_rx_valid     <= 1'b0;
      o_rx_end       <= rx_act_reg && !ctl_receive;
      rx_act_reg     <= ctl_receive;
      o_status_valid <= ctl_status;
      if (ctl_status)
        o_status_data <= i_phy_data;
      if (ctl_receive)
      begin
        if (rx_beat_reg == beats_m1)
        begin
          rx_beat_reg <= 2'h0;
          o_rx_valid  <= 1'b1;
          case (i_speed)
            `LPP_SPD_100: o_rx_data <= {rx_acc_reg[5:0], i_phy_data[0:1]};
            `LPP_SPD_200: o_rx_data <= {rx_acc_reg[3:0], i_phy_data[0:3]};
            default:      o_rx_data <= i_phy_data;
          endcase
        end
        else
        begin
          rx_beat_reg <= rx_beat_reg + 2'h1;
          rx_acc_reg  <= (i_speed == `LPP_SPD_100) ? {rx_acc_reg[5:0], i_phy_data[0:1]}
                                                 : {rx_acc_reg[3:0], i_phy_data[0:3]};
        end
      end
      else
        rx_beat_reg <= 2'h0;
    end
  end

  // ----------------------------------------------------------------------
  // Aux clock, isolation and cycle tick
  // ----------------------------------------------------------------------
  always @(posedge i_ref_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      o_half_rate_aux_clock <= 1'b0;
      o_bushold_enable      <= 1'b0;
      cyc_cnt_reg           <= 12'h000;
      ext_prev_reg          <= 1'b0;
      o_cycle_tick_output   <= 1'b0;
    end
    else
    begin
      o_half_rate_aux_clock <= !o_half_rate_aux_clock;
      o_bushold_enable      <= i_iso_select_n;
      ext_prev_reg          <= i_external_cycle_start;
      // An external start realigns the internal timer so switching back is seamless.
      if (i_cycle_source_ext)
      begin
        o_cycle_tick_output <= ext_edge;
        if (ext_edge)
          cyc_cnt_reg <= 12'h000;
        else if (cyc_cnt_reg != CYCLE_LAST)
          cyc_cnt_reg <= cyc_cnt_reg + 12'h001;
      end
      else
      begin
        o_cycle_tick_output <= (cyc_cnt_reg == CYCLE_LAST);
        cyc_cnt_reg         <= (cyc_cnt_reg == CYCLE_LAST) ? 12'h000 : cyc_cnt_reg + 12'h001;
      end
    end
  end

endmodule

// >>> hw/lpp_regs.vh
/*
  Constants for the link-side PHY port: speed codes, control-line codes,
  link-request framing and cycle timing.
  Assumes inclusion by bare name from the design files under hw/.
*/
`ifndef LPP_REGS_VH
`define LPP_REGS_VH

// ----------------------------------------------------------------------
// Speed codes
// ----------------------------------------------------------------------
`define LPP_SPD_100      2'h0
`define LPP_SPD_200      2'h1
`define LPP_SPD_400      2'h2

// ----------------------------------------------------------------------
// Control line codes
// ----------------------------------------------------------------------
`define LPP_CTL_IDLE     2'h0
`define LPP_CTL_STATUS   2'h1
`define LPP_CTL_RECEIVE  2'h2
`define LPP_CTL_GRANT    2'h3
`define LPP_CTL_TRANSMIT 2'h1

// ----------------------------------------------------------------------
// Link request framing
// ----------------------------------------------------------------------
`define LPP_LINK_REQUEST_LEN     5'h11
`define LPP_LINK_REQUEST_BUS     3'h1
`define LPP_LINK_REQUEST_READ    3'h5
`define LPP_LINK_REQUEST_WRITE   3'h6

// ----------------------------------------------------------------------
// Timing and transmit buffer depth
// ----------------------------------------------------------------------
`define LPP_CLK_PERIOD_NS   40
`define LPP_BUS_CYCLE_NS    125000
`define LPP_FIFO_DEPTH      32

`endif

// >>> hw/lpp_fifo.v
/*
  Synchronous FIFO with valid/ready on both sides, used in the transmit
  data path of the link-side PHY port.
  Assumes one clock and an asynchronous active-high reset.
*/
`timescale 1ns/1ps

module lpp_fifo #(
  parameter DW    = 9,
  parameter DEPTH = 32,
  parameter AW    = 5
) (
  input  wire          i_ref_clk,
  input  wire          i_rst,
  input  wire [DW-1:0] i_wr_data,
  input  wire          i_wr_valid,
  output wire          o_wr_ready,
  output wire [DW-1:0] o_rd_data,
  output wire          o_rd_valid,
  input  wire          i_rd_ready
);

  reg [DW-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_ptr_reg;
  reg [AW-1:0] rd_ptr_reg;
  reg [AW:0]   count_reg;

  wire push = i_wr_valid && o_wr_ready;
  wire pop  = o_rd_valid && i_rd_ready;

  assign o_wr_ready = (count_reg != DEPTH[AW:0]);
  assign o_rd_valid = (count_reg != {(AW+1){1'b0}});
  assign o_rd_data  = mem[rd_ptr_reg];

  always @(posedge i_ref_clk)
  begin
    if (push)
      mem[wr_ptr_reg] <= i_wr_data;
  end

  always @(posedge i_ref_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      wr_ptr_reg <= {AW{1'b0}};
      rd_ptr_reg <= {AW{1'b0}};
      count_reg  <= {(AW+1){1'b0}};
    end
    else
    begin
      if (push)
        wr_ptr_reg <= (wr_ptr_reg == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr_reg + 1'b1;
      if (pop)
        rd_ptr_reg <= (rd_ptr_reg == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr_reg + 1'b1;
      if (push && !pop)
        count_reg <= count_reg + 1'b1;
      else if (pop && !push)
        count_reg <= count_reg - 1'b1;
    end
  end

endmodule

// >>> dv/lpp_port_sva.sv
/*
  Checker for lpp_port: clocks, cycle tick, link request framing, line ownership, receive lanes.
  Assumes one clock, the asynchronous active-high reset, and the bind at the foot of this file.
*/
`timescale 1ns/1ps
`include "lpp_regs.vh"

module lpp_port_chk (
  input wire       i_ref_clk,
  input wire       i_rst,
  input wire [1:0] i_speed,
  input wire       i_reg_req,
  input wire       o_reg_ready,
  input wire [7:0] o_rx_data,
  input wire       o_rx_valid,
  input wire [0:1] i_link_phy_control_lines,
  input wire       o_link_phy_control_lines_oe,
  input wire [0:7] i_phy_data,
  input wire       o_phy_data_oe,
  input wire       o_link_request,
  input wire       i_iso_select_n,
  input wire       o_bushold_enable,
  input wire       o_half_rate_aux_clock,
  input wire       i_external_cycle_start,
  input wire       i_cycle_source_ext,
  input wire       o_cycle_tick_output
);
  reg [11:0] gap_reg;

  // Edges since the last tick; any tick restarts it, matching the realigned internal timer.
  always @(posedge i_ref_clk or posedge i_rst)
    if (i_rst)
      gap_reg <= 12'h000;
    else
      gap_reg <= o_cycle_tick_output ? 12'h001 : gap_reg + 12'h001;

  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);

  property p_aux; !$past(i_rst) |-> o_half_rate_aux_clock != $past(o_half_rate_aux_clock); endproperty
  a_aux: assert property (p_aux) else $error("aux clock missed a toggle");
  property p_tick_int; o_cycle_tick_output && !i_cycle_source_ext |-> gap_reg == 12'hC35; endproperty
  a_tick_int: assert property (p_tick_int) else $error("internal tick period wrong");
  property p_tick_ext; i_cycle_source_ext && $rose(i_external_cycle_start) |=> o_cycle_tick_output; endproperty
  a_tick_ext: assert property (p_tick_ext) else $error("external start gave no tick");
  property p_req_go; i_reg_req && o_reg_ready |=> !o_reg_ready ##1 o_link_request; endproperty
  a_req_go: assert property (p_req_go) else $error("request start bit missing");
  property p_req_len; i_reg_req && o_reg_ready |-> ##18 !o_link_request && o_reg_ready; endproperty
  a_req_len: assert property (p_req_len) else $error("request frame length wrong");
  property p_oe_pair; o_link_phy_control_lines_oe == o_phy_data_oe; endproperty
  a_oe_pair: assert property (p_oe_pair) else $error("control and data enables differ");
  property p_grant; $rose(o_link_phy_control_lines_oe) |-> $past(i_link_phy_control_lines) == `LPP_CTL_GRANT;
  endproperty
  a_grant: assert property (p_grant) else $error("link drove lines without grant");
  property p_rx400;
    !o_phy_data_oe && i_link_phy_control_lines == `LPP_CTL_RECEIVE && i_speed == `LPP_SPD_400
      |=> o_rx_valid && o_rx_data == $past(i_phy_data);
  endproperty
  a_rx400: assert property (p_rx400) else $error("receive byte at full width wrong");
  property p_bush; !$past(i_rst) |-> o_bushold_enable == $past(i_iso_select_n); endproperty
  a_bush: assert property (p_bush) else $error("bushold enable does not follow select");
endmodule

bind lpp_port lpp_port_chk i_chk (
  .i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_speed(i_speed), .i_reg_req(i_reg_req), .o_reg_ready(o_reg_ready),
  .o_rx_data(o_rx_data), .o_rx_valid(o_rx_valid), .i_link_phy_control_lines(i_link_phy_control_lines),
  .o_link_phy_control_lines_oe(o_link_phy_control_lines_oe), .i_phy_data(i_phy_data),
  .o_phy_data_oe(o_phy_data_oe), .o_link_request(o_link_request), .i_iso_select_n(i_iso_select_n),
  .o_bushold_enable(o_bushold_enable), .o_half_rate_aux_clock(o_half_rate_aux_clock),
  .i_external_cycle_start(i_external_cycle_start), .i_cycle_source_ext(i_cycle_source_ext),
  .o_cycle_tick_output(o_cycle_tick_output));

// >>> dv/lpp_phy_model.sv
/*
  Behavioural PHY facing lpp_port: decodes link requests, grants the bus,
  drives receive and status cycles, and collects transmitted bytes.
  Assumes it shares the port's clock and sees the port's speed setting.
*/
`timescale 1ns/1ps
`include "lpp_regs.vh"

module lpp_phy_model #(
  parameter GAP = 20
) (
  input  wire       i_ref_clk,
  input  wire [1:0] i_speed,
  input  wire       i_link_request,
  input  wire [0:1] i_ctl_link,
  input  wire       i_ctl_oe,
  input  wire [0:7] i_data_link,
  input  wire       i_data_oe,
  output wire [0:1] o_ctl,
  output wire [0:7] o_data
);
  reg [0:1]  ctl_reg = 2'h0;
  reg [0:7]  dat_reg = 8'h00;
  reg [0:9]  last    = 10'h000;
  reg        drv_reg = 1'b1;
  reg        own_reg = 1'b0;
  reg        was_oe  = 1'b0;
  reg        gnt_en  = 1'b1;
  reg        pend    = 1'b0;
  reg [15:0] req_reg = 16'h0000;
  reg [7:0]  acc     = 8'h00;
  integer    rbits   = 0;
  integer    wait_n  = 0;
  integer    beats   = 0;
  integer    n_req   = 0;
  reg [7:0]  txq[$];

  // Undriven lines show the inverse of their last level, so stale data never passes for driven data.
  assign o_ctl  = i_ctl_oe  ? i_ctl_link  : (drv_reg ? ctl_reg : ~last[0:1]);
  assign o_data = i_data_oe ? i_data_link : (drv_reg ? dat_reg : ~last[2:9]);

  always @(posedge i_ref_clk)
  begin
    last <= {o_ctl, o_data};
    was_oe <= i_data_oe;
    if (rbits > 0)
    begin
      req_reg = {req_reg[14:0], i_link_request};
      rbits = rbits - 1;
      if (rbits == 0)
      begin
        n_req = n_req + 1;
        pend = (req_reg[15:13] == `LPP_LINK_REQUEST_BUS);
        wait_n = GAP;
      end
    end
    else if (i_link_request)
      rbits = 16;
    if (own_reg && drv_reg)
    begin
      drv_reg <= 1'b0;
      ctl_reg <= `LPP_CTL_IDLE;
    end
    else if (own_reg && was_oe && !i_ctl_oe)
    begin
      drv_reg <= 1'b1;
      own_reg <= 1'b0;
    end
    else if (pend && gnt_en && wait_n > 0)
      wait_n = wait_n - 1;
    else if (pend && gnt_en)
    begin
      ctl_reg <= `LPP_CTL_GRANT;
      own_reg <= 1'b1;
      pend = 1'b0;
    end
    if (i_data_oe && was_oe && i_ctl_link == `LPP_CTL_TRANSMIT)
    begin
      acc = (i_speed == `LPP_SPD_100) ? {acc[5:0], i_data_link[0:1]} :
            (i_speed == `LPP_SPD_200) ? {acc[3:0], i_data_link[0:3]} : i_data_link;
      beats = beats + 1;
      if (beats == (4 >> i_speed))
      begin
        txq.push_back(acc);
        beats = 0;
      end
    end
  end

  task put(input [0:1] c, input [7:0] d);
  begin
    @(posedge i_ref_clk);
    ctl_reg <= c;
    dat_reg <= d;
  end
  endtask

  // Unused lanes carry a fixed pattern so that a port reading them is caught.
  task rx_byte(input [7:0] b, input [1:0] s);
    reg [7:0] sh;
    reg [7:0] m;
    integer   k;
  begin
    sh = b;
    m = ~(8'hFF >> (2 << s));
    for (k = 0; k < (4 >> s); k = k + 1)
    begin
      put(`LPP_CTL_RECEIVE, (sh & m) | (~m & 8'hA5));
      sh = sh << (2 << s);
    end
  end
  endtask
endmodule

// >>> dv/tb_lpp_port.sv
/*
  Self-checking bench for lpp_port with the behavioural PHY on its far side.
  Assumes the checker file is compiled alongside and binds itself.
*/
`timescale 1ns/1ps
`include "lpp_regs.vh"
`define CHK(g, e) begin n_tests = n_tests + 1; if ((g) !== (e)) begin failures = failures + 1; \
  $display("BAD t=%0t got=%0h exp=%0h", $time, (g), (e)); end end

module tb_lpp_port;
  typedef struct packed { logic [1:0] spd; logic [7:0] b0; logic [7:0] b1; } lpp_row_t;
  reg        i_ref_clk = 1'b0;
  reg        i_rst     = 1'b1;
  reg  [1:0] spd       = `LPP_SPD_400;
  reg  [7:0] tx_data   = 8'h00;
  reg        tx_last   = 1'b0;
  reg        tx_valid  = 1'b0;
  reg        rq        = 1'b0;
  reg        rq_w      = 1'b0;
  reg  [3:0] rq_a      = 4'h0;
  reg  [7:0] rq_d      = 8'h00;
  reg        iso_n     = 1'b1;
  reg        ext_start = 1'b0;
  reg        ext_sel   = 1'b0;
  reg        r1;
  wire       tx_ready, rq_ready, rx_valid, ctl_oe, dat_oe, link_request, bush, aux, tick, rx_end, st_vld;
  wire [7:0] rx_data, st_data;
  wire [0:1] ctl_o, ctl_w;
  wire [0:7] dat_o, dat_w;
  integer    failures = 0;
  integer    n_tests  = 0;
  integer    i, k, n;
  reg  [7:0] rxq[$];
  lpp_row_t  rows [0:2] = '{'{`LPP_SPD_100, 8'hC3, 8'h5A}, '{`LPP_SPD_200, 8'h81, 8'h7E},
                           '{`LPP_SPD_400, 8'h96, 8'h3C}};

  always #20 i_ref_clk = ~i_ref_clk;
  always @(posedge i_ref_clk) if (rx_valid === 1'b1) rxq.push_back(rx_data);

  lpp_port i_dut (
    .i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_speed(spd), .i_tx_data(tx_data), .i_tx_last(tx_last),
    .i_tx_valid(tx_valid), .o_tx_ready(tx_ready), .i_reg_req(rq), .i_reg_write(rq_w), .i_reg_addr(rq_a),
    .i_reg_wdata(rq_d), .o_reg_ready(rq_ready), .o_rx_data(rx_data), .o_rx_valid(rx_valid), .o_rx_end(rx_end),
    .o_status_data(st_data), .o_status_valid(st_vld), .i_link_phy_control_lines(ctl_w),
    .o_link_phy_control_lines(ctl_o), .o_link_phy_control_lines_oe(ctl_oe), .i_phy_data(dat_w),
    .o_phy_data(dat_o), .o_phy_data_oe(dat_oe), .o_link_request(link_request), .i_iso_select_n(iso_n),
    .o_bushold_enable(bush), .o_half_rate_aux_clock(aux), .i_external_cycle_start(ext_start),
    .i_cycle_source_ext(ext_sel), .o_cycle_tick_output(tick));

  lpp_phy_model i_phy (
    .i_ref_clk(i_ref_clk), .i_speed(spd), .i_link_request(link_request), .i_ctl_link(ctl_o), .i_ctl_oe(ctl_oe),
    .i_data_link(dat_o), .i_data_oe(dat_oe), .o_ctl(ctl_w), .o_data(dat_w));

  task clk(input integer c);
    repeat (c) @(posedge i_ref_clk);
  endtask

  task reg_acc(input w, input [3:0] a, input [7:0] d);
  begin
    n = i_phy.n_req;
    rq <= 1'b1;
    rq_w <= w;
    rq_a <= a;
    rq_d <= d;
    k = 0;
    do begin clk(1); k = k + 1; end while (rq_ready !== 1'b1 && k < 40);
    rq <= 1'b0;
    while (i_phy.n_req == n && k < 80) begin clk(1); k = k + 1; end
    `CHK(i_phy.req_reg, {w ? `LPP_LINK_REQUEST_WRITE : `LPP_LINK_REQUEST_READ, a, d, 1'b0})
  end
  endtask

  task wait_tx(input integer c);
  begin
    k = 0;
    while ((i_phy.txq.size() < c || dat_oe !== 1'b0) && k < 900) begin clk(1); k = k + 1; end
  end
  endtask

  task final_report;
  begin
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  end
  endtask

  initial
  begin
    #(40 * 20000);
    failures = failures + 1;
    final_report;
  end

  initial
  begin
    clk(5);
    `CHK({ctl_oe, dat_oe, aux, tick, ctl_o, link_request}, 7'h00)
    i_rst <= 1'b0;
    clk(3);
    r1 = aux;
    clk(1);
    `CHK(aux, ~r1)
    $display("reset and aux clock done");
    for (i = 0; i < 3; i = i + 1)
    begin
      spd <= rows[i].spd;
      clk(1);
      i_phy.rx_byte(rows[i].b0, rows[i].spd);
      i_phy.rx_byte(rows[i].b1, rows[i].spd);
      i_phy.put(`LPP_CTL_IDLE, 8'h00);
      clk(2);
      `CHK(rx_end, 1'b1)
      `CHK({rxq[0], rxq[1]}, {rows[i].b0, rows[i].b1})
      rxq.delete();
      tx_valid <= 1'b1;
      tx_data <= rows[i].b1;
      clk(1);
      tx_data <= rows[i].b0;
      tx_last <= 1'b1;
      clk(1);
      tx_valid <= 1'b0;
      tx_last <= 1'b0;
      wait_tx(2);
      `CHK({i_phy.txq[0], i_phy.txq[1]}, {rows[i].b1, rows[i].b0})
      `CHK(i_phy.req_reg, {`LPP_LINK_REQUEST_BUS, 12'h000, 1'b0})
      i_phy.txq.delete();
      $display("row %0d done", i);
    end
    reg_acc(1'b1, 4'hA, 8'h5C);
    reg_acc(1'b0, 4'h3, 8'h00);
    $display("register requests done");
    i_phy.gnt_en = 1'b0;
    n = 0;
    tx_valid <= 1'b1;
    repeat (40) begin tx_data <= n[7:0]; tx_last <= (n == 31); clk(1); if (tx_ready === 1'b1) n = n + 1; end
    tx_valid <= 1'b0;
    `CHK(n, 32)
    i_phy.gnt_en = 1'b1;
    wait_tx(32);
    for (i = 0; i < 32; i = i + 1)
      `CHK(i_phy.txq[i], i[7:0])
    $display("buffer fill and drain done");
    i_phy.put(`LPP_CTL_STATUS, 8'h3C);
    i_phy.put(`LPP_CTL_IDLE, 8'h00);
    clk(1);
    `CHK({st_data, st_vld}, {8'h3C, 1'b1})
    iso_n <= 1'b0;
    clk(2);
    `CHK(bush, 1'b0)
    iso_n <= 1'b1;
    clk(2);
    `CHK(bush, 1'b1)
    $display("status and bushold done");
    k = 0;
    while (tick !== 1'b1 && k < 3200) begin clk(1); k = k + 1; end
    n = 0;
    do begin clk(1); n = n + 1; end while (tick !== 1'b1 && n < 3200);
    `CHK(n, 3125)
    ext_sel <= 1'b1;
    clk(2);
    ext_start <= 1'b1;
    clk(2);
    `CHK(tick, 1'b1)
    ext_start <= 1'b0;
    ext_sel <= 1'b0;
    i_rst <= 1'b1;
    clk(2);
    `CHK({aux, tick, ctl_oe}, 3'h0)
    i_rst <= 1'b0;
    clk(3);
    $display("cycle tick and second reset done");
    final_report;
  end
endmodule
